// File: shared/udc_pkg.sv
package udc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] OFS_DEVICE_CONTROL    = 12'h804;
  localparam logic [11:0] OFS_DEVICE_STATUS     = 12'h808;
  localparam logic [11:0] OFS_IN_COMMON_MASK    = 12'h810;
  localparam logic [11:0] OFS_OUT_COMMON_MASK   = 12'h814;
  localparam logic [11:0] OFS_ALL_EP_SUMMARY    = 12'h818;

  // ****************************************************************
  // Device control fields
  // ****************************************************************
  localparam int BIT_PERIODIC_XFER_INT = 15;
  localparam int POS_PKT_TURN          = 13;
  localparam int BIT_POWER_DONE        = 11;
  localparam int BIT_CLR_OUT_NAK       = 10;
  localparam int BIT_SET_OUT_NAK       = 9;
  localparam int BIT_CLR_IN_NAK        = 8;
  localparam int BIT_SET_IN_NAK        = 7;
  localparam int POS_TEST_MODE         = 4;
  localparam int BIT_OUT_NAK_STATE     = 3;
  localparam int BIT_IN_NAK_STATE      = 2;
  localparam int BIT_SOFT_DETACH       = 1;
  localparam int BIT_REMOTE_WAKE       = 0;
  localparam logic [1:0] PKT_TURN_RESET = 2'h1;
  localparam logic [15:0] CTRL_RW_MASK  = 16'h0873;

  // Device status fields
  localparam int POS_SOF_FRAME   = 8;
  localparam int BIT_ERRATIC     = 3;
  localparam int POS_ENUM_SPEED  = 1;
  localparam int BIT_SUSPEND     = 0;

  localparam logic [31:0] IN_MASK_RW  = 32'h0000_237f;
  localparam logic [31:0] OUT_MASK_RW = 32'h0000_735f;

  // ****************************************************************
  // Operating modes and test codes
  // ****************************************************************
  localparam logic [1:0] OPMODE_NORMAL = 2'h0;
  localparam logic [1:0] OPMODE_NODRV  = 2'h1;
  localparam logic [2:0] TEST_OFF      = 3'h0;
  localparam logic [2:0] TEST_FORCE_EN = 3'h5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ          = 125;
  localparam int WAKE_L1_US       = 50;
  localparam int WAKE_L1_CYCLES   = WAKE_L1_US * CLK_MHZ;
  localparam int ERRATIC_MS       = 2;
  localparam int ERRATIC_CYCLES   = ERRATIC_MS * 1000 * CLK_MHZ;
  localparam int SUSPEND_MS       = 3;
  localparam int SUSPEND_CYCLES   = SUSPEND_MS * 1000 * CLK_MHZ;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [15:0] in_ev;
    logic [15:0] out_ev;
  } udc_ep_events_t;

  typedef struct packed {
    logic       out_nak;
    logic       in_nak;
    logic       drop_out_data;
    logic [2:0] test_mode;
    logic [1:0] opmode;
  } udc_link_ctrl_t;

endpackage : udc_pkg

// File: hdl/udc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module udc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : udc_sync
`default_nettype wire

// File: hdl/udc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Counts while run is high; done pulses when the count is reached
module udc_timer #(
  parameter int LIMIT = 16
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Control
  input  wire logic run,
  output logic      done
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);
  logic [CW-1:0] cnt_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (!run || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign done = run && (cnt_q == LAST);
endmodule : udc_timer
`default_nettype wire

// File: hdl/udc_device_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module udc_device_ctrl #(
  parameter int WAKE_L1_CYCLES = udc_pkg::WAKE_L1_CYCLES,
  parameter int ERRATIC_CYCLES = udc_pkg::ERRATIC_CYCLES,
  parameter int SUSPEND_CYCLES = udc_pkg::SUSPEND_CYCLES
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  // Register port
  input  wire logic [11:0]             reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  // Configuration from elsewhere in the core
  input  wire logic                    sg_dma_on,
  input  wire logic                    lpm_l1_sleep,
  // Transceiver pins
  input  wire logic                    phy_rx_valid,
  input  wire logic                    phy_rx_active,
  input  wire logic [1:0]              phy_line_state,
  // Protocol engine events
  input  wire logic                    sof_seen,
  input  wire logic [13:0]             sof_number,
  input  wire logic                    chirp_done,
  input  wire logic [1:0]              chirp_speed,
  input  wire logic                    np_in_timeout,
  input  wire logic                    periodic_frames_done,
  input  wire udc_pkg::udc_ep_events_t ep_events,
  // Status and control toward the engines
  output udc_pkg::udc_link_ctrl_t      link_ctrl,
  output logic [1:0]                   packets_per_endpoint_turn,
  output logic                         power_on_reprogram_done,
  output logic                         remote_wake_active,
  output logic                         l1_resume_active,
  output logic                         suspend_state,
  output logic                         early_suspend_flag,
  output logic                         periodic_xfer_done
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [1:0]  pkt_turn_q;
  logic        per_int_q;
  logic        power_done_q;
  logic [2:0]  test_mode_q;
  logic        soft_detach_q;
  logic        remote_wake_q;
  logic        wake_l1_q;
  logic        out_nak_q;
  logic        in_nak_q;
  logic [13:0] sof_frame_q;
  logic        erratic_q;
  logic [1:0]  speed_q;
  logic        suspend_q;
  logic        early_susp_q;
  logic [31:0] in_mask_q;
  logic [31:0] out_mask_q;
  logic [31:0] rdata_q;
  logic        per_done_q;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pins_s;

  udc_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .d        ({phy_rx_valid, phy_rx_active, phy_line_state}),
    .q        (pins_s)
  );

  logic       rx_busy;
  logic [1:0] line_s;
  logic [1:0] line_prev_q;
  logic       line_change;

  assign rx_busy     = pins_s[3] | pins_s[2];
  assign line_s      = pins_s[1:0];
  assign line_change = line_s != line_prev_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      line_prev_q <= 2'h0;
    end else begin
      line_prev_q <= line_s;
    end
  end

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic wr_ctrl;
  logic wr_stat;
  logic wr_in_mask;
  logic wr_out_mask;

  assign wr_ctrl     = reg_wr && reg_addr == udc_pkg::OFS_DEVICE_CONTROL;
  assign wr_stat     = reg_wr && reg_addr == udc_pkg::OFS_DEVICE_STATUS;
  assign wr_in_mask  = reg_wr && reg_addr == udc_pkg::OFS_IN_COMMON_MASK;
  assign wr_out_mask = reg_wr && reg_addr == udc_pkg::OFS_OUT_COMMON_MASK;

  logic wake_set;
  assign wake_set = wr_ctrl && reg_wdata[udc_pkg::BIT_REMOTE_WAKE];

  // ****************************************************************
  // Control fields
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pkt_turn_q    <= udc_pkg::PKT_TURN_RESET;
      per_int_q     <= 1'b0;
      power_done_q  <= 1'b0;
      test_mode_q   <= udc_pkg::TEST_OFF;
      soft_detach_q <= 1'b0;
    end else if (wr_ctrl) begin
      pkt_turn_q    <= reg_wdata[udc_pkg::POS_PKT_TURN +: 2];
      per_int_q     <= reg_wdata[udc_pkg::BIT_PERIODIC_XFER_INT];
      power_done_q  <= reg_wdata[udc_pkg::BIT_POWER_DONE];
      test_mode_q   <= reg_wdata[udc_pkg::POS_TEST_MODE +: 3];
      soft_detach_q <= reg_wdata[udc_pkg::BIT_SOFT_DETACH];
    end
  end

  // Write-only strobes act here and store nothing; a set beats a clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_nak_q <= 1'b0;
    end else if (wr_ctrl && reg_wdata[udc_pkg::BIT_SET_OUT_NAK]) begin
      out_nak_q <= 1'b1;
    end else if (wr_ctrl && reg_wdata[udc_pkg::BIT_CLR_OUT_NAK]) begin
      out_nak_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      in_nak_q <= 1'b0;
    end else if ((wr_ctrl && reg_wdata[udc_pkg::BIT_SET_IN_NAK])
                 || np_in_timeout) begin
      in_nak_q <= 1'b1;
    end else if (wr_ctrl && reg_wdata[udc_pkg::BIT_CLR_IN_NAK]) begin
      in_nak_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Remote wakeup
  // ****************************************************************
  logic wake_l1_done;

  udc_timer #(.LIMIT(WAKE_L1_CYCLES)) u_l1_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .run      (wake_l1_q),
    .done     (wake_l1_done)
  );

  // Outside L1 software owns the bit and must clear it itself
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      remote_wake_q <= 1'b0;
      wake_l1_q     <= 1'b0;
    end else if (wr_ctrl) begin
      remote_wake_q <= reg_wdata[udc_pkg::BIT_REMOTE_WAKE];
      wake_l1_q     <= wake_set && lpm_l1_sleep;
    end else if (wake_l1_done) begin
      remote_wake_q <= 1'b0;
      wake_l1_q     <= 1'b0;
    end
  end

  // ****************************************************************
  // Status: SOF, speed, erratic error, suspend
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sof_frame_q <= 14'h0;
    end else if (sof_seen) begin
      sof_frame_q <= sof_number;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      speed_q <= 2'h0;
    end else if (chirp_done) begin
      speed_q <= chirp_speed;
    end
  end

  logic erratic_hit;
  logic idle_hit;

  udc_timer #(.LIMIT(ERRATIC_CYCLES)) u_err_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .run      (rx_busy && !soft_detach_q && !erratic_q),
    .done     (erratic_hit)
  );

  udc_timer #(.LIMIT(SUSPEND_CYCLES)) u_idle_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .run      (!line_change && !suspend_q && !soft_detach_q),
    .done     (idle_hit)
  );

  // Erratic state is left only through a detach cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      erratic_q <= 1'b0;
    end else if (erratic_hit) begin
      erratic_q <= 1'b1;
    end else if (soft_detach_q) begin
      erratic_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      early_susp_q <= 1'b0;
    end else if (erratic_hit) begin
      early_susp_q <= 1'b1;
    end else if (wr_stat && reg_wdata[udc_pkg::BIT_ERRATIC]) begin
      early_susp_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      suspend_q <= 1'b0;
    end else if (erratic_hit || idle_hit) begin
      suspend_q <= 1'b1;
    end else if (wake_set || (line_change && !erratic_q)) begin
      suspend_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Endpoint masks and summary
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      in_mask_q  <= 32'h0;
      out_mask_q <= 32'h0;
    end else begin
      if (wr_in_mask) begin
        in_mask_q <= reg_wdata & udc_pkg::IN_MASK_RW;
      end
      if (wr_out_mask) begin
        out_mask_q <= reg_wdata & udc_pkg::OUT_MASK_RW;
      end
    end
  end

  // Engines present per-endpoint pending lines already filtered by the
  // mask bit matching their cause; any enabled cause qualifies here
  logic [31:0] summary;
  assign summary = {ep_events.out_ev & {16{|out_mask_q}},
                    ep_events.in_ev  & {16{|in_mask_q}}};

  // ****************************************************************
  // Periodic transfer completion
  // ****************************************************************
  // One-cycle pulse; the engine tells when every programmed frame is done
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      per_done_q <= 1'b0;
    end else begin
      per_done_q <= periodic_frames_done && per_int_q && !sg_dma_on;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [31:0] ctrl_view;
  logic [31:0] stat_view;

  always_comb begin
    ctrl_view = 32'h0;
    ctrl_view[udc_pkg::BIT_PERIODIC_XFER_INT] = per_int_q;
    ctrl_view[udc_pkg::POS_PKT_TURN +: 2] =
      sg_dma_on ? pkt_turn_q : 2'h0;
    ctrl_view[udc_pkg::BIT_POWER_DONE]    = power_done_q;
    ctrl_view[udc_pkg::POS_TEST_MODE +: 3] = test_mode_q;
    ctrl_view[udc_pkg::BIT_OUT_NAK_STATE] = out_nak_q;
    ctrl_view[udc_pkg::BIT_IN_NAK_STATE]  = in_nak_q;
    ctrl_view[udc_pkg::BIT_SOFT_DETACH]   = soft_detach_q;
    ctrl_view[udc_pkg::BIT_REMOTE_WAKE]   = remote_wake_q;
    stat_view = 32'h0;
    stat_view[udc_pkg::POS_SOF_FRAME +: 14] = sof_frame_q;
    stat_view[udc_pkg::BIT_ERRATIC]         = erratic_q;
    stat_view[udc_pkg::POS_ENUM_SPEED +: 2] = speed_q;
    stat_view[udc_pkg::BIT_SUSPEND]         = suspend_q;
  end

  // Zero outside the read slot, so a late sample never sees stale data
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        udc_pkg::OFS_DEVICE_CONTROL:  rdata_q <= ctrl_view;
        udc_pkg::OFS_DEVICE_STATUS:   rdata_q <= stat_view;
        udc_pkg::OFS_IN_COMMON_MASK:  rdata_q <= in_mask_q;
        udc_pkg::OFS_OUT_COMMON_MASK: rdata_q <= out_mask_q;
        udc_pkg::OFS_ALL_EP_SUMMARY:  rdata_q <= summary;
        default:                      rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Detach forces non-driving mode and OUT NAK with data drop; IN NAK is left to in_nak_q
  always_comb begin
    link_ctrl.opmode = soft_detach_q ? udc_pkg::OPMODE_NODRV
                                     : udc_pkg::OPMODE_NORMAL;
    link_ctrl.out_nak       = out_nak_q || soft_detach_q;
    link_ctrl.drop_out_data = out_nak_q || soft_detach_q;
    link_ctrl.in_nak        = in_nak_q;
    // Reserved codes keep the transceiver out of any test state
    link_ctrl.test_mode     = test_mode_q > udc_pkg::TEST_FORCE_EN
                              ? udc_pkg::TEST_OFF : test_mode_q;
  end

  assign reg_rdata                 = rdata_q;
  assign packets_per_endpoint_turn = sg_dma_on ? pkt_turn_q : 2'h0;
  assign power_on_reprogram_done   = power_done_q;
  assign remote_wake_active        = remote_wake_q && !wake_l1_q;
  assign l1_resume_active          = wake_l1_q;
  assign suspend_state             = suspend_q;
  assign early_suspend_flag        = early_susp_q;
  assign periodic_xfer_done        = per_done_q;

endmodule : udc_device_ctrl
`default_nettype wire

// File: tb/udc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host and transceiver seen from the device pins
// ****************************************************************
module udc_host_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Scenario control
  input  wire logic       busy,
  input  wire logic       stuck,
  // Transceiver pins
  input  wire logic [1:0] opmode,
  output logic            phy_rx_valid,
  output logic            phy_rx_active,
  output logic [1:0]      phy_line_state
);
  logic [2:0] cnt_q;
  logic       gone;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Detached device sees no traffic and a zero line
  assign gone = (opmode == udc_pkg::OPMODE_NODRV);
  // Faulty transceiver holds receive high
  assign phy_rx_valid  = stuck && !gone;
  assign phy_rx_active = stuck && !gone;
  // Traffic moves the line; an idle bus holds J
  assign phy_line_state = gone ? 2'h0 : busy ? {cnt_q[2], ~cnt_q[2]} : 2'h1;
endmodule : udc_host_model
`default_nettype wire

// File: tb/udc_device_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module udc_device_ctrl_checker #(
  parameter int WAKE_L1_CYCLES = 16
) (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    resetn,
  // Register port
  input wire logic [11:0]             reg_addr,
  input wire logic [31:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [31:0]             reg_rdata,
  // Events and outputs
  input wire logic                    sg_dma_on,
  input wire logic                    np_in_timeout,
  input wire udc_pkg::udc_ep_events_t ep_events,
  input wire udc_pkg::udc_link_ctrl_t link_ctrl,
  input wire logic [1:0]              packets_per_endpoint_turn,
  input wire logic                    l1_resume_active,
  input wire logic                    suspend_state,
  input wire logic                    early_suspend_flag
);
  logic wr_ctl;
  int   l1_cnt_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  assign wr_ctl = reg_wr && reg_addr == udc_pkg::OFS_DEVICE_CONTROL;

  // Long resume would hold the host bus past its window
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      l1_cnt_q <= 0;
    end else begin
      l1_cnt_q <= l1_resume_active ? l1_cnt_q + 1 : 0;
    end
  end

  property p_opmode;
    wr_ctl |=> link_ctrl.opmode == ($past(reg_wdata[1]) ? 2'h1 : 2'h0);
  endproperty
  a_opmode: assert property (p_opmode)
    else $error("opmode does not follow soft detach");
  property p_out_set;
    wr_ctl && reg_wdata[9] |=> link_ctrl.out_nak && link_ctrl.drop_out_data;
  endproperty
  a_out_set: assert property (p_out_set)
    else $error("out nak not set");
  property p_out_clr;
    wr_ctl && reg_wdata[10] && !reg_wdata[9] && !reg_wdata[1] |=>
      !link_ctrl.out_nak;
  endproperty
  a_out_clr: assert property (p_out_clr)
    else $error("out nak not cleared");
  property p_in_tmo;
    np_in_timeout |=> link_ctrl.in_nak;
  endproperty
  a_in_tmo: assert property (p_in_tmo)
    else $error("timeout did not set in nak");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_pkt_off;
    !sg_dma_on |-> packets_per_endpoint_turn == 2'h0;
  endproperty
  a_pkt_off: assert property (p_pkt_off)
    else $error("packet turn field not zero");
  property p_test;
    wr_ctl && reg_wdata[6:4] <= 3'h5 |=>
      link_ctrl.test_mode == $past(reg_wdata[6:4]);
  endproperty
  a_test: assert property (p_test)
    else $error("test mode mismatch");
  property p_l1;
    l1_cnt_q <= WAKE_L1_CYCLES + 1;
  endproperty
  a_l1: assert property (p_l1)
    else $error("L1 resume did not end");
  property p_early;
    $rose(early_suspend_flag) |-> suspend_state;
  endproperty
  a_early: assert property (p_early)
    else $error("early suspend without suspend");
  property p_sum0;
    reg_rd && reg_addr == udc_pkg::OFS_ALL_EP_SUMMARY && ep_events == 32'h0
      |=> reg_rdata == 32'h0;
  endproperty
  a_sum0: assert property (p_sum0)
    else $error("summary set without events");
endmodule : udc_device_ctrl_checker

bind udc_device_ctrl udc_device_ctrl_checker #(
  .WAKE_L1_CYCLES(WAKE_L1_CYCLES)
) u_chk (
  .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sg_dma_on(sg_dma_on),
  .np_in_timeout(np_in_timeout), .ep_events(ep_events),
  .link_ctrl(link_ctrl),
  .packets_per_endpoint_turn(packets_per_endpoint_turn),
  .l1_resume_active(l1_resume_active), .suspend_state(suspend_state),
  .early_suspend_flag(early_suspend_flag)
);
`default_nettype wire

// File: tb/udc_device_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module udc_device_ctrl_tb;
  localparam int WK = 20;
  localparam int ER = 40;
  localparam int SU = 60;
  localparam logic [11:0] CTL = udc_pkg::OFS_DEVICE_CONTROL;
  localparam logic [11:0] STS = udc_pkg::OFS_DEVICE_STATUS;
  localparam logic [11:0] SUM = udc_pkg::OFS_ALL_EP_SUMMARY;
  logic core_clk, resetn, reg_wr, reg_rd, sg_dma_on, lpm_l1_sleep;
  logic phy_rx_valid, phy_rx_active, sof_seen, chirp_done, np_in_timeout;
  logic busy, stuck, rd_seen, pwr, rwk, l1r, susp, early, pxd, pfd;
  logic [1:0]  phy_line_state, chirp_speed, ppt;
  logic [13:0] sof_number;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v, m_e, m_m, exp_q[$], msk_q[$];
  logic [2:0]  tc;
  udc_pkg::udc_ep_events_t ep_events;
  udc_pkg::udc_link_ctrl_t link_ctrl;
  int n_fail, total_checks, cyc_n;

  always #4 core_clk = ~core_clk;

  udc_device_ctrl #(.WAKE_L1_CYCLES(WK), .ERRATIC_CYCLES(ER),
    .SUSPEND_CYCLES(SU)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sg_dma_on(sg_dma_on),
    .lpm_l1_sleep(lpm_l1_sleep), .phy_rx_valid(phy_rx_valid),
    .phy_rx_active(phy_rx_active), .phy_line_state(phy_line_state),
    .sof_seen(sof_seen), .sof_number(sof_number), .chirp_done(chirp_done),
    .chirp_speed(chirp_speed), .np_in_timeout(np_in_timeout),
    .periodic_frames_done(pfd), .ep_events(ep_events),
    .link_ctrl(link_ctrl), .packets_per_endpoint_turn(ppt),
    .power_on_reprogram_done(pwr), .remote_wake_active(rwk),
    .l1_resume_active(l1r), .suspend_state(susp),
    .early_suspend_flag(early), .periodic_xfer_done(pxd));

  udc_host_model u_host (.core_clk(core_clk), .resetn(resetn),
    .busy(busy), .stuck(stuck), .opmode(link_ctrl.opmode),
    .phy_rx_valid(phy_rx_valid), .phy_rx_active(phy_rx_active),
    .phy_line_state(phy_line_state));

  task automatic give_verdict;
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  // Expectation is queued before the strobe so the monitor finds it
  task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask : rd

  always @(posedge core_clk) begin
    if (rd_seen) begin
      m_e = exp_q.pop_front();
      m_m = msk_q.pop_front();
      `CHK(reg_rdata & m_m, m_e)
    end
    rd_seen = reg_rd;
    cyc_n++;
    if (cyc_n == 4000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    {core_clk, resetn, reg_wr, reg_rd, sg_dma_on, lpm_l1_sleep} = '0;
    {sof_seen, chirp_done, np_in_timeout, stuck, pfd} = '0;
    {reg_addr, reg_wdata, sof_number, chirp_speed, ep_events} = '0;
    busy = 1'b1;
    void'($urandom(3));
    cyc(10);
    resetn <= 1'b1;
    `CHK({link_ctrl, ppt}, 10'h0)
    rd(CTL, 32'h0, 32'h7fff);
    rd(STS, 32'h0, 32'hffffffff);
    rd(SUM, 32'h0, 32'hffffffff);
    rd(12'h81c, 32'h0, 32'hffffffff);
    // ****************************************************************
    // Masks and summary
    // ****************************************************************
    for (int i = 0; i < 2; i++) begin
      v = $urandom;
      wr(i ? 12'h814 : 12'h810, v);
      rd(i ? 12'h814 : 12'h810, v & (i ? udc_pkg::OUT_MASK_RW
        : udc_pkg::IN_MASK_RW), 32'hffffffff);
      wr(i ? 12'h814 : 12'h810, 32'h1);
    end
    v = $urandom;
    @(posedge core_clk);
    ep_events <= v;
    rd(SUM, {v[15:0], v[31:16]}, 32'hffffffff);
    wr(12'h810, 32'h0);
    rd(SUM, {v[15:0], 16'h0}, 32'hffffffff);
    wr(12'h814, 32'h0);
    rd(SUM, 32'h0, 32'hffffffff);
    ep_events <= '0;
    // ****************************************************************
    // Control bits
    // ****************************************************************
    // Effective flags are set whenever a NAK is requested
    for (int k = 0; k < 2; k++) begin
      wr(CTL, k ? 32'h80 : 32'h600);
      `CHK(link_ctrl[7:5], k ? 3'h2 : 3'h5)
      rd(CTL, k ? 32'h4 : 32'h8, 32'h7fff);
      wr(CTL, k ? 32'h100 : 32'h400);
      `CHK(link_ctrl[7:5], 3'h0)
    end
    @(posedge core_clk);
    np_in_timeout <= 1'b1;
    @(posedge core_clk);
    np_in_timeout <= 1'b0;
    rd(CTL, 32'h4, 32'h7fff);
    for (int c = 0; c < 8; c++) begin
      tc = c[2:0];
      wr(CTL, {25'h0, tc, 4'h0});
      `CHK(link_ctrl.test_mode, tc <= 3'h5 ? tc : 3'h0)
      rd(CTL, {25'h0, tc, 4'h0}, 32'h70);
    end
    wr(CTL, 32'h800);
    `CHK(pwr, 1'b1)
    rd(CTL, 32'h804, 32'h7fff);
    wr(CTL, 32'h2);
    `CHK(link_ctrl.opmode, udc_pkg::OPMODE_NODRV)
    wr(CTL, 32'h0);
    `CHK(link_ctrl.opmode, udc_pkg::OPMODE_NORMAL)
    wr(CTL, 32'h8000);
    pfd <= 1'b1;
    @(posedge core_clk);
    pfd <= 1'b0;
    @(posedge core_clk);
    `CHK(pxd, 1'b1)
    sg_dma_on <= 1'b1;
    wr(CTL, 32'h6000);
    `CHK(ppt, 2'h3)
    rd(CTL, 32'h6000, 32'h6000);
    sg_dma_on <= 1'b0;
    rd(CTL, 32'h0, 32'h6000);
    // ****************************************************************
    // Frame number, speed, wake, suspend, erratic
    // ****************************************************************
    for (int s = 0; s < 4; s++) begin
      v = $urandom;
      @(posedge core_clk);
      {sof_seen, chirp_done, sof_number, chirp_speed} <= {2'h3, v[13:0],
        2'(s)};
      @(posedge core_clk);
      {sof_seen, chirp_done} <= 2'h0;
      rd(STS, {10'h0, v[13:0], 5'h0, 2'(s), 1'b0},
        32'hffffffff);
    end
    lpm_l1_sleep <= 1'b1;
    wr(CTL, 32'h1);
    `CHK(l1r, 1'b1)
    cyc(WK + 4);
    `CHK(l1r, 1'b0)
    rd(CTL, 32'h0, 32'h1);
    lpm_l1_sleep <= 1'b0;
    busy <= 1'b0;
    cyc(SU + 10);
    `CHK(susp, 1'b1)
    rd(STS, 32'h1, 32'h1);
    busy <= 1'b1;
    cyc(10);
    `CHK(susp, 1'b0)
    busy <= 1'b0;
    cyc(SU + 10);
    wr(CTL, 32'h1);
    `CHK({rwk, susp}, 2'h2)
    cyc(8);
    wr(CTL, 32'h0);
    `CHK(rwk, 1'b0)
    busy <= 1'b1;
    stuck <= 1'b1;
    cyc(ER + 10);
    `CHK({early, susp}, 2'h3)
    rd(STS, 32'h8, 32'h8);
    stuck <= 1'b0;
    wr(CTL, 32'h2);
    wr(CTL, 32'h0);
    rd(STS, 32'h0, 32'h8);
    wr(STS, 32'h8);
    `CHK(early, 1'b0)
    cyc(4);
    give_verdict();
  end
endmodule : udc_device_ctrl_tb
`default_nettype wire
